//--- asr_top.sv
/*
  analog reference source select and external reset handling.
  assumes synchronous terminal inputs, a simple register port with
  read data one cycle after the strobe, and a 25 MHz clock.
*/
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
// Contract
// - select asserted: reference from current input over 4-20 mA span
// - select deasserted: reference from voltage input over 0-10 V span
// - select unassigned: reference is sum of voltage and current inputs
// - reset operation runs when reset input goes active then released
// - alarm cleared within 30 ms of reset onset
// - reset active: motor off, trip cleared, power-up reset applied
// - reset held over 4 s since power-up flags comm error; key clears
// - stop/reset key resets only while an alarm is present
// - reset terminal is active high only, no inversion
// - power-up runs the same reset operation as a reset pulse
// - with remote operator, local key works only few seconds after power-up
// - reset while running cuts drive at once, motor coasts
// - outputs with nonzero off delay are not forced off by reset
// - after alarm clear, motor restarts at once if run is active
module asr_top
  import asr_pkg::*;
#(
  parameter int P_MS_CYCLES = MS_CYCLES
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // terminals and keypad
  input wire logic I_EXTERNAL_RESET_INPUT,
  input wire logic I_ANALOG_SOURCE_SELECT,
  input wire logic I_RUN,
  input wire logic I_KEY_STOP,
  input wire logic I_TRIP_EVENT,
  // analog and digital references
  input wire logic [9:0] I_VOLT_REF,
  input wire logic [9:0] I_CURRENT_REFERENCE_INPUT,
  input wire logic [10:0] I_DIG_REF,
  // output requests from the drive core
  input wire logic I_OUT1_REQ,
  input wire logic I_OUT2_REQ,
  input wire logic I_RELAY_REQ,
  // register port
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  // drive outputs
  output logic [10:0] O_FREQ_REF,
  output logic O_MOTOR_EN,
  output logic O_ALARM,
  output logic O_OUT1,
  output logic O_OUT2,
  output logic O_RELAY_OUTPUT,
  output logic O_RESET_OP,
  output logic O_COMM_ERR,
  output logic O_IRQ
);
  typedef struct packed {
    logic [3:0] ctrl;
    logic [23:0] dly;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [31:0] rdata;
    logic [10:0] freq_ref;
    logic motor_en;
    logic trip;
    logic out1;
    logic out2;
    logic relay;
    logic reset_op;
    logic por_pend;
    logic comm_err;
    logic key_prev;
    logic [11:0] pwr_ms;
  } asr_top_s;

  asr_top_s s;
  asr_top_s next_s;
  asr_rst_if rq ();

  // reset terminal qualification
  asr_rst_qual #(
    .P_MS_CYCLES(P_MS_CYCLES)
  ) u_qual (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_rs(I_EXTERNAL_RESET_INPUT),
    .rq(rq)
  );

  logic [1:0] frequency_source_setting;
  logic asel_assigned;
  logic remote_connected;
  logic [9:0] curr_span;
  logic [11:0] curr_prod;
  logic [10:0] curr_scaled;
  logic [10:0] volt_scaled;
  logic [10:0] ref_sel;
  logic key_rise;
  logic key_ok;
  logic key_reset;
  logic [ST_W-1:0] events;

  // current above the 4 mA point, rescaled to full span
  always_comb begin
    frequency_source_setting = s.ctrl[CTRL_FSRC_LSB +: 2];
    asel_assigned = s.ctrl[CTRL_ASEL_BIT];
    remote_connected = s.ctrl[CTRL_REMOTE_BIT];
    curr_span = (I_CURRENT_REFERENCE_INPUT > CURR_ZERO) ? (I_CURRENT_REFERENCE_INPUT - CURR_ZERO) : 10'h000;
    curr_prod = {2'h0, curr_span} * CURR_GAIN;
    curr_scaled = {1'b0, curr_prod[11:2]};
    volt_scaled = {1'b0, I_VOLT_REF};
  end

  // reference source: analog terminals only with source setting 01
  always_comb begin
    if (frequency_source_setting != FSRC_ANALOG) begin
      ref_sel = I_DIG_REF;
    end else if (!asel_assigned) begin
      ref_sel = volt_scaled + {1'b0, I_CURRENT_REFERENCE_INPUT};
    end else if (I_ANALOG_SOURCE_SELECT) begin
      ref_sel = curr_scaled;
    end else begin
      ref_sel = volt_scaled;
    end
  end

  // keypad: local key locked out late when a remote operator is attached
  always_comb begin
    key_rise = I_KEY_STOP && !s.key_prev;
    key_ok = !remote_connected || (s.pwr_ms < KEY_WINDOW_CNT);
    key_reset = key_rise && key_ok && s.trip;
    events = '0;
    events[ST_RESET] = rq.done || s.por_pend || key_reset;
    events[ST_TRIP] = I_TRIP_EVENT && !rq.held && !s.trip;
    events[ST_COMM] = rq.long_hold && !s.comm_err;
    events[ST_KEY] = key_reset;
  end

  // main next-state logic
  always_comb begin
    next_s = s;
    next_s.key_prev = I_KEY_STOP;
    next_s.por_pend = 1'b0;
    next_s.freq_ref = ref_sel;
    if (rq.tick && s.pwr_ms != MS_CNT_MAX) begin
      next_s.pwr_ms = s.pwr_ms + 12'h001;
    end
    // power-up takes the same path as a qualified pulse
    next_s.reset_op = events[ST_RESET];
    // trip: cleared by a held reset, the key or power-up
    if (rq.held || key_reset || s.por_pend) begin
      next_s.trip = 1'b0;
    end
    if (I_TRIP_EVENT && !rq.held) begin
      next_s.trip = 1'b1;
    end
    // drive cut without ramp; restart follows run at once
    next_s.motor_en = I_RUN && !s.trip && !rq.active && !s.por_pend;
    // outputs with an off delay keep following their request
    next_s.out1 = I_OUT1_REQ && (!rq.active || s.dly[DLY_OUT1_LSB +: 8] != 8'h00);
    next_s.out2 = I_OUT2_REQ && (!rq.active || s.dly[DLY_OUT2_LSB +: 8] != 8'h00);
    next_s.relay = I_RELAY_REQ && (!rq.active || s.dly[DLY_RELAY_LSB +: 8] != 8'h00);
    // comm error: any key after release clears it; a new set wins
    if (key_rise && !rq.active) begin
      next_s.comm_err = 1'b0;
    end
    if (rq.long_hold) begin
      next_s.comm_err = 1'b1;
    end
    // register writes; the inversion bit of the terminal is not kept
    if (I_WR) begin
      case (I_ADDR)
        ADDR_CTRL: next_s.ctrl = I_WDATA[3:0];
        ADDR_DLY: next_s.dly = I_WDATA[23:0];
        ADDR_MASK: next_s.mask = I_WDATA[ST_W-1:0];
        default: next_s.ctrl = s.ctrl;
      endcase
    end
    // reads: data only in the cycle after the strobe
    next_s.rdata = 32'h00000000;
    if (I_RD) begin
      case (I_ADDR)
        ADDR_CTRL: next_s.rdata = {28'h0000000, s.ctrl};
        ADDR_DLY: next_s.rdata = {8'h00, s.dly};
        ADDR_STAT: next_s.rdata = {28'h0000000, s.status};
        ADDR_MASK: next_s.rdata = {28'h0000000, s.mask};
        ADDR_STATE: next_s.rdata = {24'h000000, rq.held, rq.active, s.comm_err, I_ANALOG_SOURCE_SELECT,
                                    s.relay, s.out2, s.motor_en, s.trip};
        default: next_s.rdata = 32'h00000000;
      endcase
    end
    // sticky status: cleared by its read, an event in that cycle survives
    if (I_RD && I_ADDR == ADDR_STAT) begin
      next_s.status = events;
    end else begin
      next_s.status = s.status | events;
    end
  end

  // state register; power-up leaves a reset operation pending
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      s <= '{ctrl: CTRL_RST, dly: DLY_RST, status: '0, mask: MASK_RST, rdata: 32'h00000000,
             freq_ref: 11'h000, motor_en: 1'b0, trip: 1'b0, out1: 1'b0, out2: 1'b0, relay: 1'b0,
             reset_op: 1'b0, por_pend: 1'b1, comm_err: 1'b0, key_prev: 1'b0, pwr_ms: 12'h000};
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state
  assign O_RDATA = s.rdata;
  assign O_FREQ_REF = s.freq_ref;
  assign O_MOTOR_EN = s.motor_en;
  assign O_ALARM = s.trip;
  assign O_OUT1 = s.out1;
  assign O_OUT2 = s.out2;
  assign O_RELAY_OUTPUT = s.relay;
  assign O_RESET_OP = s.reset_op;
  assign O_COMM_ERR = s.comm_err;
  assign O_IRQ = |(s.status & s.mask);

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);

  sequence seq_analog_sel;
    frequency_source_setting == FSRC_ANALOG && asel_assigned;
  endsequence

  AST_SEL_CURRENT: assert property (seq_analog_sel and I_ANALOG_SOURCE_SELECT |=> O_FREQ_REF == $past(curr_scaled))
    else $error("current reference not selected");
  AST_SEL_VOLTAGE: assert property (seq_analog_sel and !I_ANALOG_SOURCE_SELECT |=> O_FREQ_REF == $past(volt_scaled))
    else $error("voltage reference not selected");
  AST_SUM_UNASSIGNED: assert property (frequency_source_setting == FSRC_ANALOG && !asel_assigned
                                       |=> O_FREQ_REF == $past(volt_scaled) + $past({1'b0, I_CURRENT_REFERENCE_INPUT}))
    else $error("unassigned select does not sum inputs");
  AST_ALARM_CLEAR: assert property (rq.held |=> !O_ALARM)
    else $error("alarm still set after qualified reset");
  AST_MOTOR_CUT: assert property (rq.active |=> !O_MOTOR_EN)
    else $error("motor drive not cut during reset");
  AST_KEY_NO_ALARM: assert property (key_rise && !s.trip && !rq.done && !s.por_pend |=> !O_RESET_OP)
    else $error("key reset without alarm");
  AST_POWERUP_OP: assert property ($past(I_SYS_RST, 2) && !$past(I_SYS_RST) |-> O_RESET_OP ##1 !O_RESET_OP)
    else $error("no reset operation after power-up");
  AST_RELAY_KEPT: assert property (rq.active && s.dly[DLY_RELAY_LSB +: 8] != 8'h00 && I_RELAY_REQ |=> O_RELAY_OUTPUT)
    else $error("delayed relay forced off by reset");
  AST_RESTART: assert property (!O_ALARM && I_RUN && !rq.active && !s.por_pend |=> O_MOTOR_EN)
    else $error("motor did not restart after clear");
endmodule

//--- asr_pkg.sv
/*
  constants shared by the analog select / external reset block:
  register offsets, field positions, reset values and timing counts.
  assumes a 25 MHz system clock; all times are counted in ms ticks.
*/
package asr_pkg;
  // clock and the ms tick
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_CYCLES = CLK_HZ / 1000;

  // times in their own unit, then as counts of ms ticks
  localparam int RESET_MIN_MS = 12;
  localparam int ALARM_CLR_MS = 30;
  localparam int LONG_HOLD_S = 4;
  localparam int KEY_WINDOW_S = 3;
  localparam logic [11:0] RESET_MIN_CNT = 12'(RESET_MIN_MS);
  localparam logic [11:0] ALARM_CLR_CNT = 12'(ALARM_CLR_MS);
  localparam logic [11:0] LONG_HOLD_CNT = 12'(LONG_HOLD_S * 1000);
  localparam logic [11:0] KEY_WINDOW_CNT = 12'(KEY_WINDOW_S * 1000);
  localparam logic [11:0] MS_CNT_MAX = 12'hfff;

  // register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DLY = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0c;
  localparam logic [7:0] ADDR_STATE = 8'h10;

  // control fields
  localparam int CTRL_FSRC_LSB = 0;
  localparam int CTRL_ASEL_BIT = 2;
  localparam int CTRL_REMOTE_BIT = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [1:0] FSRC_ANALOG = 2'h1;

  // off-delay fields, one byte each
  localparam int DLY_OUT1_LSB = 0;
  localparam int DLY_OUT2_LSB = 8;
  localparam int DLY_RELAY_LSB = 16;
  localparam logic [23:0] DLY_RST = 24'h000000;

  // status / mask bits
  localparam int ST_W = 4;
  localparam int ST_RESET = 0;
  localparam int ST_TRIP = 1;
  localparam int ST_COMM = 2;
  localparam int ST_KEY = 3;
  localparam logic [3:0] MASK_RST = 4'h0;

  // current input: code of the 4 mA zero point on a 0..20 mA scale
  localparam logic [9:0] CURR_ZERO = 10'h0cd;
  localparam logic [11:0] CURR_GAIN = 12'h005;
endpackage

//--- asr_rst_if.sv
/*
  carrier between the reset input qualifier and the top module.
  assumes one clock domain; the qualifier drives every signal.
*/
`timescale 1ns/1ns
interface asr_rst_if;
  logic tick;
  logic active;
  logic held;
  logic done;
  logic long_hold;
  modport src (output tick, output active, output held, output done, output long_hold);
  modport snk (input tick, input active, input held, input done, input long_hold);
endinterface

//--- asr_rst_qual.sv
/*
  reset input qualifier: registers the terminal, makes a ms tick,
  measures the active width and the hold since power-up.
  assumes the terminal is already synchronous to the clock.
*/
`timescale 1ns/1ns
module asr_rst_qual
  import asr_pkg::*;
#(
  parameter int P_MS_CYCLES = MS_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // terminal, active high only
  input wire logic i_rs,
  // results
  asr_rst_if.src rq
);
  typedef struct packed {
    logic [15:0] pre;
    logic tick;
    logic active;
    logic [11:0] ms_cnt;
    logic held;
    logic done;
    logic armed;
    logic since_pwr;
    logic long_hold;
  } asr_qual_s;

  asr_qual_s s;
  asr_qual_s next_s;

  // tick, width count and pulse qualification
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.pre == 16'(P_MS_CYCLES - 1)) begin
      next_s.pre = 16'h0000;
      next_s.tick = 1'b1;
    end else begin
      next_s.pre = s.pre + 16'h0001;
    end
    // no inversion option: high is active, always
    next_s.active = i_rs;
    if (!s.active) begin
      next_s.ms_cnt = 12'h000;
    end else if (s.tick && s.ms_cnt != MS_CNT_MAX) begin
      next_s.ms_cnt = s.ms_cnt + 12'h001;
    end
    // short glitches never clear a trip
    next_s.held = s.active && (s.held || s.ms_cnt >= RESET_MIN_CNT);
    next_s.done = s.held && !s.active;
    next_s.armed = 1'b1;
    if (s.armed && !s.active) begin
      next_s.since_pwr = 1'b0;
    end
    next_s.long_hold = s.since_pwr && s.active && (s.ms_cnt > LONG_HOLD_CNT);
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= '{pre: 16'h0000, tick: 1'b0, active: 1'b0, ms_cnt: 12'h000, held: 1'b0,
             done: 1'b0, armed: 1'b0, since_pwr: 1'b1, long_hold: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign rq.tick = s.tick;
  assign rq.active = s.active;
  assign rq.held = s.held;
  assign rq.done = s.done;
  assign rq.long_hold = s.long_hold;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence seq_held_then_off;
    s.held && !s.active;
  endsequence

  AST_DONE_ON_RELEASE: assert property (seq_held_then_off |=> s.done ##1 !s.done)
    else $error("reset operation not issued once on release");
  AST_MIN_WIDTH: assert property ($rose(s.held) |-> $past(s.ms_cnt) >= RESET_MIN_CNT)
    else $error("reset accepted before minimum width");
  AST_LONG_HOLD: assert property (s.long_hold |-> $past(s.since_pwr) && $past(s.ms_cnt) > LONG_HOLD_CNT)
    else $error("long hold flagged too early");
  AST_ACTIVE_HIGH: assert property (!i_rs |=> !s.active)
    else $error("reset terminal active while low");
endmodule

//--- asr_sw_model.sv
/*
  external switch model for the reset terminal.
  assumes one clock; a go pulse starts a pulse of i_ms ms.
*/
`timescale 1ns/1ns
module asr_sw_model #(
  parameter int P_MS_CYCLES = 20
) (
  // clock and command
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [7:0] i_ms,
  // terminal side
  output logic o_rs,
  output logic o_busy
);
  int cnt;
  initial begin
    o_rs = 1'b0;
    o_busy = 1'b0;
    cnt = 0;
  end
  // normally open contact: closed means high, never inverted
  always @(posedge i_clk) begin
    if (i_go && !o_busy) begin
      o_busy <= 1'b1;
      o_rs <= 1'b1;
      cnt <= i_ms * P_MS_CYCLES;
    end else if (o_busy) begin
      if (cnt > 1) begin
        cnt <= cnt - 1;
      end else begin
        o_rs <= 1'b0;
        o_busy <= 1'b0;
      end
    end
  end
endmodule

//--- tb_top.sv
/*
  self-checking bench for the analog select / reset block.
  assumes the design package and a shortened ms tick.
*/
`timescale 1ns/1ns
module tb_top;
  import asr_pkg::*;
  localparam int PMS = 10;
  // long-hold scenario alone needs about 4000 ms of ticks
  localparam int CYC_MAX = 60000;
  logic clk, rst, asel, run, key, trip, o1r, o2r, rlr, wr, rd, go;
  logic [9:0] vref, cref;
  logic [10:0] dref, fref;
  logic [7:0] addr, ms;
  logic [31:0] wdata, rdata, d;
  logic motor, alarm, out1, out2, relay, rop, comm, irq, rs, busy, lhold;
  logic [3:0] ctl;
  int err_total, compares, ops, cyc, n, i, base;
  int seed = 32'h985a85ba;
  asr_sw_model #(.P_MS_CYCLES(PMS)) sw (.i_clk(clk), .i_go(go), .i_ms(ms), .o_rs(rs), .o_busy(busy));
  asr_top #(.P_MS_CYCLES(PMS)) dut (.I_CLK(clk), .I_SYS_RST(rst), .I_EXTERNAL_RESET_INPUT(rs | lhold),
    .I_ANALOG_SOURCE_SELECT(asel), .I_RUN(run), .I_KEY_STOP(key), .I_TRIP_EVENT(trip),
    .I_VOLT_REF(vref), .I_CURRENT_REFERENCE_INPUT(cref), .I_DIG_REF(dref), .I_OUT1_REQ(o1r),
    .I_OUT2_REQ(o2r), .I_RELAY_REQ(rlr), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .O_FREQ_REF(fref), .O_MOTOR_EN(motor), .O_ALARM(alarm), .O_OUT1(out1),
    .O_OUT2(out2), .O_RELAY_OUTPUT(relay), .O_RESET_OP(rop), .O_COMM_ERR(comm), .O_IRQ(irq));
  // clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // count reset-op pulses and cycles; cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (rop === 1'b1) ops++;
    if (cyc >= CYC_MAX) begin
      err_total++;
      $display("mismatch %0t timeout", $time);
      wrap_up();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task pulse_trip();
    @(posedge clk);
    trip <= 1'b1;
    @(posedge clk);
    trip <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task rs_start(input logic [7:0] w);
    @(posedge clk);
    go <= 1'b1;
    ms <= w;
    @(posedge clk);
    go <= 1'b0;
  endtask
  task wait_idle();
    while (busy === 1'b1) @(posedge clk);
    repeat (8) @(posedge clk);
    #1;
  endtask
  // one press of the keypad stop/reset key
  task key_tap();
    @(posedge clk);
    key <= 1'b1;
    repeat (4) @(posedge clk);
    key <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  function automatic logic [10:0] exp_ref(logic [3:0] c, logic s, logic [9:0] v, logic [9:0] q, logic [10:0] g);
    logic [12:0] t;
    if (c[1:0] != FSRC_ANALOG) return g;
    if (!c[CTRL_ASEL_BIT]) return 11'(v) + 11'(q);
    if (!s) return 11'(v);
    t = (q > CURR_ZERO) ? 13'(q - CURR_ZERO) : 13'h0000;
    return 11'((t * 13'(CURR_GAIN)) >> 2);
  endfunction
  task wrap_up();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    {rst, asel, run, key, trip, o1r, o2r, rlr, wr, rd, go} = 11'h400;
    {vref, cref, dref, addr, ms, wdata} = '0;
    lhold = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_reg(ADDR_CTRL, d);
    chk(d, 32'h00000000);
    chk(32'(ops), 32'h00000001);
    rd_reg(ADDR_STAT, d);
    chk(d & 32'h00000001, 32'h00000001);
    // reference source, with clamp and full-scale corners
    for (i = 0; i < 30; i++) begin
      ctl = (i % 3 == 0) ? 4'h0 : (i % 3 == 1) ? 4'h1 : 4'h5;
      wr_reg(ADDR_CTRL, 32'(ctl));
      vref <= 10'($random(seed));
      cref <= (i == 5) ? 10'h0cc : (i == 8) ? 10'h3ff : 10'($random(seed));
      dref <= 11'($random(seed));
      asel <= (i == 5) | (i == 8) | 1'($random(seed));
      repeat (3) @(posedge clk);
      #1 chk(32'(fref), 32'(exp_ref(ctl, asel, vref, cref, dref)));
    end
    // trip, then a full reset pulse while running
    wr_reg(ADDR_DLY, 32'h00010001);
    wr_reg(ADDR_MASK, 32'h00000002);
    rd_reg(ADDR_STAT, d);
    @(posedge clk);
    {run, o1r, o2r, rlr} <= 4'hf;
    pulse_trip();
    #1 chk(32'({alarm, motor, irq}), 32'h00000005);
    rd_reg(ADDR_STAT, d);
    chk(d & 32'h00000002, 32'h00000002);
    #1 chk(32'(irq), 32'h00000000);
    base = ops;
    rs_start(8'h0e);
    repeat (3) @(posedge clk);
    #1 chk(32'(motor), 32'h00000000);
    chk(32'({out1, out2, relay}), 32'h00000005);
    n = 3;
    while (alarm !== 1'b0 && n < 40 * PMS) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n <= ALARM_CLR_MS * PMS), 32'h00000001);
    wait_idle();
    chk(32'(ops - base), 32'h00000001);
    chk(32'(motor), 32'h00000001);
    // a pulse too short to count clears nothing
    pulse_trip();
    base = ops;
    rs_start(8'h05);
    wait_idle();
    chk(32'({alarm, 1'(ops - base)}), 32'h00000002);
    // keypad key resets only with an alarm present
    for (i = 0; i < 2; i++) begin
      base = ops;
      key_tap();
      chk(32'({alarm, 1'(ops - base)}), (i == 0) ? 32'h00000001 : 32'h00000000);
    end
    rd_reg(8'h20, d);
    chk(d, 32'h00000000);
    // second power-up with the terminal already closed
    @(posedge clk);
    rst <= 1'b1;
    lhold <= 1'b1;
    asel <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    base = ops;
    @(posedge clk);
    #1 chk(32'({motor, rop}), 32'h00000001);
    // comm error only once the hold since power-up passes 4 s
    repeat (3995 * PMS) @(posedge clk);
    #1 chk(32'(comm), 32'h00000000);
    repeat (10 * PMS) @(posedge clk);
    #1 chk(32'(comm), 32'h00000001);
    rd_reg(ADDR_STATE, d);
    chk(d, 32'h000000f0);
    @(posedge clk);
    lhold <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'(ops - base), 32'h00000002);
    // remote operator attached: a late key only clears the comm error
    wr_reg(ADDR_CTRL, 32'h00000008);
    pulse_trip();
    key_tap();
    chk(32'({comm, alarm}), 32'h00000001);
    wr_reg(ADDR_CTRL, 32'h00000000);
    key_tap();
    chk(32'(alarm), 32'h00000000);
    wrap_up();
  end
endmodule
